// >>> hdl/wir_pkg.sv
// wir_pkg: constants, types and helpers shared by the wireless io repeater
// What this block does
// R1 - link id zero: pin stays input, its level is never sent or used
// R2 - negative link id: pin is input, its level goes into outgoing packets
// R3 - positive link id: pin is output, fed by remote input with negated id
// R4 - own inputs never drive own outputs, only received entries do
// R5 - output follows the linked remote level, high for high, low for low
// R6 - with any input configured, send one packet every 7 to 10 ms
// R7 - good received packet updates every output whose id matches an entry
// R8 - fifteen pins: six of port 0, eight of port 1, one of port 2
// R9 - every output drives low after reset until a packet changes it
// R10 - one input may feed any number of outputs sharing one id
// R11 - integrator keeps input ids unique across units
// R12 - channel setting 0 to 255, default 128, peers must match
// R13 - link id held per pin, addressed by port and pin number
// R14 - host serial port carries no payload, only a bootloader request
// R15 - entries matching no local output are dropped without effect
package wir_pkg;

    localparam int NPINS = 15;

    // register byte addresses
    localparam logic [7:0] ADR_CHANNEL = 8'h00;
    localparam logic [7:0] ADR_OUT = 8'h04;
    localparam logic [7:0] ADR_IN = 8'h08;
    localparam logic [7:0] ADR_LINK_BASE = 8'h40;
    localparam logic [4:0] PIN_NONE = 5'h1f;

    // reset values: pin 0 is input -1, pin 14 is output 1
    localparam logic [7:0] CHANNEL_RST = 8'h80;
    localparam logic [NPINS*8-1:0] LINK_RST = {8'h01, {13{8'h00}}, 8'hff};
    localparam logic [15:0] LFSR_RST = 16'hace1;
    localparam logic [NPINS:0] SYNC_RST = 16'h7fff;

    // timing
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int TX_MIN_MS = 7;
    localparam int TX_MAX_MS = 10;
    localparam int TX_MIN_TICKS = TX_MIN_MS * 1000000 / TICK_NS;
    localparam int TX_SPAN_TICKS = (TX_MAX_MS - TX_MIN_MS) * 1000000 / TICK_NS;

    localparam int FIFO_DEPTH = 8;

    // one byte of a radio frame with its end marker
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } wir_byte_t;

    localparam int BYTE_W = $bits(wir_byte_t);

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_CHAN = 2'b01,
        TX_COUNT = 2'b10,
        TX_ENTRY = 2'b11
    } wir_tx_state_t;

    // map port*8+pin to pin slot, PIN_NONE where no pin exists
    function automatic logic [4:0] wir_pin_of(input logic [5:0] idx);
        if (idx < 6'd6)
            return {1'b0, idx[3:0]};
        else if (idx >= 6'd8 && idx < 6'd16)
            return 5'(idx - 6'd2);
        else if (idx == 6'd17)
            return 5'd14;
        else
            return PIN_NONE;
    endfunction

endpackage

// >>> hdl/wir_sync3.sv
// wir_sync3: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module wir_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // s1 only feeds s2, so metastability never reaches logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit moves only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RST;
        end else begin
            q_o <= (s2_q & s3_q) | (q_o & (s2_q ^ s3_q));
        end
    end
endmodule // wir_sync3
`default_nettype wire

// >>> hdl/wir_fifo.sv
// wir_fifo: byte fifo with registered head for the transmit path
`timescale 1ns/1ps
`default_nettype none
module wir_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic load;

    // head register counts as one extra slot beyond the array
    assign in_ready_o = (cnt_q != FULL);
    assign push = in_valid_i && in_ready_o;
    assign load = (cnt_q != '0) && (!out_valid_o || out_ready_i);

    // storage, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (load) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // output stage keeps outputs straight from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (load) begin
            out_valid_o <= 1'b1;
            out_data_o <= mem_q[rd_q];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule // wir_fifo
`default_nettype wire

// >>> hdl/wir_repeater.sv
// wir_repeater: wireless io repeater core with wishbone registers
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wir_repeater
    import wir_pkg::*;
#(
    parameter int TX_MIN_TICKS_P = TX_MIN_TICKS,
    parameter int TX_SPAN_TICKS_P = TX_SPAN_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // general pins
    input wire logic [NPINS-1:0] pin_in_i,
    output logic [NPINS-1:0] pin_out_o,
    output logic [NPINS-1:0] pin_oe_o,
    // radio link
    output logic [7:0] channel_o,
    output logic tx_valid_o,
    output wir_byte_t tx_byte_o,
    input wire logic tx_ready_i,
    input wire logic rx_valid_i,
    input wire wir_byte_t rx_byte_i,
    input wire logic rx_good_i,
    // host serial side
    input wire logic host_boot_req_i,
    output logic boot_req_o
);
    logic [NPINS:0] sync_lvl;
    logic [NPINS-1:0] lvl;
    logic [7:0] link_q [NPINS];
    logic [7:0] channel_q;
    logic [NPINS-1:0] is_in;
    logic [NPINS-1:0] is_out;
    logic [NPINS-1:0] out_q;
    logic [NPINS-1:0] out_d;
    logic [NPINS-1:0] oe_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic wb_hit;
    logic [7:0] link_off;
    logic [4:0] link_pin;
    logic link_sel;
    logic [31:0] rd_data;
    logic [6:0] div_q;
    logic tick_q;
    logic [15:0] lfsr_q;
    logic [15:0] timer_q;
    logic fire;
    logic send_pend_q;
    wir_tx_state_t tx_state_q;
    logic [3:0] scan_q;
    logic [3:0] left_q;
    logic [NPINS-1:0] snap_in_q;
    logic [NPINS-1:0] snap_lvl_q;
    logic tx_start;
    logic fifo_wvalid;
    logic fifo_wready;
    wir_byte_t fifo_wdata;
    logic [3:0] in_count;
    logic [1:0] rx_pos_q;
    logic rx_bad_q;
    logic rx_bad_d;
    logic [7:0] rx_cnt_q;
    logic [3:0] rx_n_q;
    logic [3:0] rx_n_d;
    logic [7:0] ent_q [NPINS];
    logic apply_q;
    logic boot_q;

    // pins and boot request are asynchronous to clk_i
    wir_sync3 #(
        .W(NPINS + 1),
        .RST(SYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({host_boot_req_i, pin_in_i}),
        .q_o(sync_lvl)
    );
    assign lvl = sync_lvl[NPINS-1:0];

    // pin roles from the sign of each link id
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            is_in[i] = link_q[i][7]; // R2
            is_out[i] = !link_q[i][7] && (link_q[i] != 8'h00); // R3
        end
    end

    // number of inputs that go into a packet
    always_comb begin
        in_count = 4'h0;
        for (int i = 0; i < NPINS; i++) begin
            in_count = in_count + 4'(is_in[i]);
        end
    end

    // address decode: link ids sit at base + 4*(port*8+pin)
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
    assign link_off = wb_adr_i - ADR_LINK_BASE;
    assign link_pin = wir_pin_of(link_off[7:2]); // R13
    assign link_sel = (wb_adr_i >= ADR_LINK_BASE) && (wb_adr_i[1:0] == 2'b00)
                      && (link_pin != PIN_NONE); // R8

    // read mux, unmapped words read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (link_sel) begin
            rd_data = {24'h00_0000, link_q[link_pin[3:0]]};
        end else if (wb_adr_i == ADR_CHANNEL) begin
            rd_data = {24'h00_0000, channel_q};
        end else if (wb_adr_i == ADR_OUT) begin
            rd_data = {17'h0_0000, out_q};
        end else if (wb_adr_i == ADR_IN) begin
            rd_data = {17'h0_0000, lvl};
        end
    end

    // one-cycle ack, dropped the cycle after; every address answers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_hit;
            if (wb_hit) dat_q <= rd_data;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // software settings, only byte lane 0 carries data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_q <= CHANNEL_RST; // R12
            for (int i = 0; i < NPINS; i++) begin
                link_q[i] <= LINK_RST[i*8 +: 8]; // R13
            end
        end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            if (link_sel) begin
                link_q[link_pin[3:0]] <= wb_dat_i[7:0]; // R13
            end else if (wb_adr_i == ADR_CHANNEL) begin
                channel_q <= wb_dat_i[7:0]; // R12
            end
        end
    end

    // microsecond tick from the system clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 7'(TICK_CYC - 1));
            div_q <= (div_q == 7'(TICK_CYC - 1)) ? 7'h00 : div_q + 7'h01;
        end
    end

    // free-running lfsr spreads packets so two units never lock in step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_q <= LFSR_RST;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    // send interval: min ticks plus a random share of the span
    assign fire = tick_q && (timer_q == 16'h0000);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_q <= 16'(TX_MIN_TICKS_P - 1);
        end else if (fire) begin
            timer_q <= 16'(TX_MIN_TICKS_P - 1 + (int'(lfsr_q) % TX_SPAN_TICKS_P)); // R6
        end else if (tick_q) begin
            timer_q <= timer_q - 16'h0001;
        end
    end

    // pending send; a new interval end wins over the clear
    assign tx_start = (tx_state_q == TX_IDLE) && send_pend_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            send_pend_q <= 1'b0;
        end else if (fire) begin
            send_pend_q <= 1'b1;
        end else if (tx_start) begin
            send_pend_q <= 1'b0;
        end
    end

    // bytes offered to the fifo; disabled pins are skipped
    always_comb begin
        fifo_wvalid = 1'b0;
        fifo_wdata = '0;
        unique case (tx_state_q)
            TX_IDLE: begin
                fifo_wvalid = 1'b0;
            end
            TX_CHAN: begin
                fifo_wvalid = 1'b1;
                fifo_wdata = '{last: 1'b0, data: channel_q}; // R12
            end
            TX_COUNT: begin
                fifo_wvalid = 1'b1;
                fifo_wdata = '{last: 1'b0, data: {4'h0, left_q}};
            end
            TX_ENTRY: begin
                fifo_wvalid = snap_in_q[scan_q]; // R1
                fifo_wdata.last = (left_q == 4'h1);
                fifo_wdata.data = {snap_lvl_q[scan_q], 7'(8'h00 - link_q[scan_q])}; // R2
            end
        endcase
    end

    // packet builder: channel, count, one byte per input pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_q <= TX_IDLE;
            scan_q <= 4'h0;
            left_q <= 4'h0;
            snap_in_q <= '0;
            snap_lvl_q <= '0;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (tx_start && (in_count != 4'h0)) begin // R6
                        snap_in_q <= is_in; // R1
                        snap_lvl_q <= lvl;
                        left_q <= in_count;
                        scan_q <= 4'h0;
                        tx_state_q <= TX_CHAN;
                    end
                end
                TX_CHAN: begin
                    if (fifo_wready) tx_state_q <= TX_COUNT;
                end
                TX_COUNT: begin
                    if (fifo_wready) tx_state_q <= TX_ENTRY;
                end
                TX_ENTRY: begin
                    if (!snap_in_q[scan_q]) begin
                        scan_q <= scan_q + 4'h1;
                    end else if (fifo_wready) begin
                        scan_q <= scan_q + 4'h1;
                        left_q <= left_q - 4'h1;
                        if (left_q == 4'h1) tx_state_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // fifo stalls the builder when the radio is slow to drain
    wir_fifo #(
        .W(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_wvalid),
        .in_ready_o(fifo_wready),
        .in_data_i(fifo_wdata),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_byte_o)
    );

    // receive checks: channel match, sane count, no overflow
    always_comb begin
        rx_bad_d = rx_bad_q;
        rx_n_d = rx_n_q;
        unique case (rx_pos_q)
            2'd0: begin
                rx_bad_d = (rx_byte_i.data != channel_q); // R12
                rx_n_d = 4'h0;
            end
            2'd1: rx_bad_d = rx_bad_q || (rx_byte_i.data > 8'(NPINS));
            default: begin
                rx_bad_d = rx_bad_q || (rx_n_q == 4'(NPINS));
                rx_n_d = rx_n_q + 4'h1;
            end
        endcase
    end

    // collect entries; nothing applies until the whole frame is good
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_pos_q <= 2'd0;
            rx_bad_q <= 1'b0;
            rx_cnt_q <= 8'h00;
            rx_n_q <= 4'h0;
            apply_q <= 1'b0;
        end else begin
            apply_q <= 1'b0;
            if (rx_valid_i) begin
                rx_bad_q <= rx_bad_d;
                rx_n_q <= rx_n_d;
                if (rx_pos_q == 2'd1) rx_cnt_q <= rx_byte_i.data;
                if (rx_pos_q == 2'd2 && !rx_bad_d) ent_q[rx_n_q] <= rx_byte_i.data;
                if (rx_byte_i.last) begin
                    rx_pos_q <= 2'd0;
                    apply_q <= rx_good_i && !rx_bad_d && (rx_pos_q == 2'd2)
                               && ({4'h0, rx_n_d} == rx_cnt_q); // R7
                end else if (rx_pos_q != 2'd2) begin
                    rx_pos_q <= rx_pos_q + 2'd1;
                end
            end
        end
    end

    // apply entries; later entries win, unmatched ones change nothing
    always_comb begin
        out_d = out_q;
        for (int e = 0; e < NPINS; e++) begin
            for (int p = 0; p < NPINS; p++) begin
                if ((4'(e) < rx_n_q) && is_out[p]
                    && (link_q[p][6:0] == ent_q[e][6:0])) begin // R3 R10 R15
                    out_d[p] = ent_q[e][7]; // R5
                end
            end
        end
    end

    // outputs only ever come from received entries, never local inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= '0; // R9
            oe_q <= '0;
        end else begin
            oe_q <= is_out; // R1 R3
            if (apply_q) out_q <= out_d; // R4 R7
        end
    end
    assign pin_out_o = out_q;
    assign pin_oe_o = oe_q;

    // host port is a bootloader request only, no data path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_q <= 1'b0;
        end else if (sync_lvl[NPINS]) begin
            boot_q <= 1'b1; // R14
        end
    end
    assign boot_req_o = boot_q;
    assign channel_o = channel_q;

endmodule // wir_repeater
`default_nettype wire

// >>> test/wir_repeater_chk.sv
// wir_repeater_chk: port-level assertions
`timescale 1ns/1ps
`default_nettype none
module wir_repeater_chk
    import wir_pkg::*;
#(
    parameter int TX_MIN_TICKS_P = TX_MIN_TICKS,
    parameter int TX_SPAN_TICKS_P = TX_SPAN_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NPINS-1:0] pin_in_i,
    input wire logic [NPINS-1:0] pin_out_o,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic [7:0] channel_o,
    input wire logic tx_valid_o,
    input wire wir_byte_t tx_byte_o,
    input wire logic tx_ready_i,
    input wire logic rx_valid_i,
    input wire wir_byte_t rx_byte_i,
    input wire logic rx_good_i,
    input wire logic host_boot_req_i,
    input wire logic boot_req_o
);
    logic [1:0] idx_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // byte position in packet, stays at 2 for entries
    always_ff @(posedge clk_i) begin
        if (rst_i)
            idx_q <= 2'h0;
        else if (tx_valid_o && tx_ready_i)
            idx_q <= tx_byte_o.last ? 2'h0 : idx_q + {1'b0, ~idx_q[1]};
    end
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_chan_wr;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADR_CHANNEL |=> channel_o == $past(wb_dat_i[7:0]);
    endproperty
    a_chan_wr: assert property (p_chan_wr) else $error("channel not written");
    property p_rd_hi;
        wb_ack_o |-> wb_dat_o[31:15] == 17'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    // outputs move only after a good frame
    property p_out_cause;
        $changed(pin_out_o) |-> $past(rx_valid_i && rx_byte_i.last && rx_good_i, 2);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("output moved alone");
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
    property p_tx_chan;
        idx_q == 2'h0 && tx_valid_o |-> tx_byte_o.data == channel_o && !tx_byte_o.last;
    endproperty
    a_tx_chan: assert property (p_tx_chan) else $error("bad header");
    property p_tx_count;
        idx_q == 2'h1 && tx_valid_o |-> tx_byte_o.data inside {[8'h01:8'h0f]}
            && !tx_byte_o.last;
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("bad count");
    property p_boot_hold;
        boot_req_o |=> boot_req_o;
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot dropped");
    c_rx: cover property (rx_valid_i && rx_byte_i.last && rx_good_i);
    c_tx: cover property (tx_valid_o && tx_ready_i && tx_byte_o.last);
    c_stall: cover property ((tx_valid_o && !tx_ready_i) [*3]);
endmodule // wir_repeater_chk
`default_nettype wire

// >>> test/wir_peer.sv
// wir_peer: far-side radio model, sends frames, collects packets
`timescale 1ns/1ps
`default_nettype none
module wir_peer
    import wir_pkg::*;
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire wir_byte_t tx_byte_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output wir_byte_t rx_byte_o,
    output logic rx_good_o
);
    wir_byte_t pkt_q[$];
    int st_q[$];
    longint tm_q[$];
    logic [2:0] cnt_q = 3'h0;
    logic idle_q = 1'b1;
    longint cyc = 0;
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 9'h0;
        rx_good_o = 1'b0;
    end
    // slow mode grants one byte in eight
    assign tx_ready_o = !slow_i || cnt_q == 3'h0;
    // collect granted bytes, note where packets start
    always @(posedge clk_i) begin
        cyc++;
        cnt_q <= cnt_q + 3'h1;
        if (tx_valid_i && tx_ready_o) begin
            if (idle_q) begin
                st_q.push_back(pkt_q.size());
                tm_q.push_back(cyc);
            end
            pkt_q.push_back(tx_byte_i);
            idle_q <= tx_byte_i.last;
        end
    end
    // frame: channel, count, entries; crc flag with last
    task automatic send(input logic [7:0] b[6], input int n, input logic good);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_byte_o <= {i == n - 1, b[i]};
            rx_good_o <= good;
        end
        @(posedge clk_i);
        // released lines show the inverse
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
        rx_good_o <= ~rx_good_o;
    endtask
endmodule // wir_peer
`default_nettype wire

// >>> test/testbench.sv
// testbench: self-checking bench for the repeater core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench
    import wir_pkg::*;
;
    localparam int TMIN = 20;
    localparam int TSPAN = 10;
    localparam logic [14:0] LVL = 15'h2aa8;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [31:0] e;} wir_row_t;
    localparam wir_row_t ROWS [9] = '{'{8'h00, 8'hff, 32'hff}, '{8'h00, 8'h80, 32'h80},
        '{8'h44, 8'h05, 32'h05}, '{8'h60, 8'h05, 32'h05}, '{8'h4c, 8'hfd, 32'hfd},
        '{8'h58, 8'h12, 32'h0}, '{8'h88, 8'h12, 32'h0}, '{8'h04, 8'h12, 32'h0},
        '{8'h08, 8'h00, {17'h0, LVL}}};
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
    logic [7:0] wb_adr_i, channel_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic [NPINS-1:0] pin_in_i, pin_out_o, pin_oe_o;
    logic tx_valid_o, tx_ready_i, rx_valid_i, rx_good_i, host_boot_req_i, boot_req_o;
    wir_byte_t tx_byte_o, rx_byte_i;
    int n_mismatch = 0, n_compared = 0, k, j;
    longint dt;
    logic [7:0] exp_q[$];
    wir_repeater #(.TX_MIN_TICKS_P(TMIN), .TX_SPAN_TICKS_P(TSPAN)) DUT (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
        .wb_ack_o, .pin_in_i, .pin_out_o, .pin_oe_o, .channel_o, .tx_valid_o, .tx_byte_o,
        .tx_ready_i, .rx_valid_i, .rx_byte_i, .rx_good_i, .host_boot_req_i, .boot_req_o);
    wir_peer u_peer (.clk_i, .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
        .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
        .rx_good_o(rx_good_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // one frame, then check outputs after it lands
    task automatic rx(input logic [7:0] b[6], input int m, input logic g,
                      input logic [14:0] e);
        u_peer.send(b, m, g);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        `CHK(pin_out_o, e)
    endtask
    // watchdog: run needs under 30k cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        $display("Error %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        {rst_i, wb_sel_i, pin_in_i} = {1'b1, 4'h1, LVL};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, slow, host_boot_req_i} = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK(pin_out_o, 15'h0)
        `CHK(channel_o, 8'h80)
        `CHK(boot_req_o, 1'b0)
        wb(0, 8'h00, 0, rd);
        `CHK(rd, 32'h80)
        wb(0, 8'h40, 0, rd);
        `CHK(rd, 32'hff)
        wb(0, 8'h84, 0, rd);
        `CHK(rd, 32'h01)
        `CHK(pin_oe_o, 15'h4000)
        $display("test reset done");
        // register rows: write, read back, compare
        foreach (ROWS[i]) begin
            wb(1, ROWS[i].a, ROWS[i].d, rd);
            wb(0, ROWS[i].a, 0, rd);
            `CHK(rd, ROWS[i].e)
        end
        for (int i = 1; i < 8; i++)
            wb(1, 8'(8'h60 + 4 * i), 8'(-(16 + i)), rd);
        $display("test registers done");
        // received frames: shared id, later entry wins, bad channel, crc or count change nothing
        rx('{8'h80, 8'h03, 8'h85, 8'h81, 8'h89, 0}, 5, 1, 15'h4042);
        rx('{8'h80, 8'h02, 8'h85, 8'h05, 0, 0}, 4, 1, 15'h4000);
        rx('{8'h81, 8'h01, 8'h01, 0, 0, 0}, 3, 1, 15'h4000);
        rx('{8'h80, 8'h01, 8'h01, 0, 0, 0}, 3, 0, 15'h4000);
        rx('{8'h80, 8'h02, 8'h01, 0, 0, 0}, 3, 1, 15'h4000);
        `CHK(pin_oe_o, 15'h4042)
        $display("test receive done");
        // stalled far side backs up the fifo
        @(posedge clk_i);
        slow <= 1'b1;
        k = u_peer.st_q.size();
        while (u_peer.st_q.size() < k + 3)
            @(posedge clk_i);
        exp_q = '{8'h80, 8'h09, {LVL[0], 7'd1}, {LVL[3], 7'd3}};
        for (int i = 7; i < 14; i++)
            exp_q.push_back({LVL[i], 7'(i + 10)});
        j = u_peer.st_q[k + 1];
        for (int i = 0; i < 11; i++)
            `CHK(u_peer.pkt_q[j + i], {i == 10, exp_q[i]})
        dt = u_peer.tm_q[k + 2] - u_peer.tm_q[k + 1];
        // slack for the stalled grant
        `CHK(dt >= TMIN * 100 && dt < (TMIN + TSPAN) * 100 + 16, 1'b1)
        `CHK(pin_out_o, 15'h4000)
        $display("test transmit done");
        // no inputs: no packets
        slow <= 1'b0;
        wb(1, 8'h40, 0, rd);
        wb(1, 8'h4c, 0, rd);
        for (int i = 1; i < 8; i++)
            wb(1, 8'(8'h60 + 4 * i), 8'h00, rd);
        repeat (3100) @(posedge clk_i);
        k = u_peer.st_q.size();
        repeat (3100) @(posedge clk_i);
        `CHK(u_peer.st_q.size(), k)
        $display("test silence done");
        host_boot_req_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        host_boot_req_i <= 1'b0;
        repeat (6) @(negedge clk_i);
        `CHK(boot_req_o, 1'b1)
        $display("test boot done");
        conclude();
    end
endmodule // testbench
bind wir_repeater wir_repeater_chk #(
    .TX_MIN_TICKS_P(TX_MIN_TICKS_P),
    .TX_SPAN_TICKS_P(TX_SPAN_TICKS_P)
) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .pin_in_i, .pin_out_o, .pin_oe_o, .channel_o, .tx_valid_o,
    .tx_byte_o, .tx_ready_i, .rx_valid_i, .rx_byte_i, .rx_good_i, .host_boot_req_i,
    .boot_req_o);
`default_nettype wire
